// File: verilog/monitor_alert_regs.sv
// alert, limit and identification registers of a power monitor
// assumes: averaged results arrive on CLK with a one-cycle MEAS_DONE;
// register accesses arrive from a protocol engine on LINK_CLK
//
// Summary of operation
// - overflow flag bit 2 follows arithmetic overflow
// - polarity bit 1 picks pin active level
// - latch bit 0 picks latching or transparent
// - transparent mode idles once fault is gone
// - latch mode holds until mask register read
// - limit register compared with selected measurement
// - limit uses the selected measurement's number format
// - limit register sixteen bits, read/write, resets zero
// - maker code register read-only, fixed value
// - part code in die register bits 15-4
// - revision code in bits 3-0, read-only
// - at most one limit function drives the pin
// - barely-over fault alerts within 1-2 conversions
// - far-over fault may alert sooner via average
// - bits 15-11 enable functions, highest wins
// - bit 10 alerts on conversion done flag
// - done flag clears on config write, mask read
// - function flag clears per latch or transparent
`timescale 1ns/1ps
`include "monitor_alert_consts.svh"
module monitor_alert_regs
  import monitor_alert_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter logic [15:0] MAKER_CODE = 16'h1a2b, // arbitrary value
  parameter logic [11:0] PART_CODE = 12'h3c4, // arbitrary value
  parameter logic [3:0] REV_CODE = 4'h5 // arbitrary value
) (
  // core clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register access on the link clock
  input wire logic LINK_CLK,
  input wire logic REG_START,
  input wire reg_req_t REG_REQ,
  output logic [15:0] REG_RDATA,
  output logic REG_DONE,
  output logic REG_BUSY,
  // results and events from the measurement engine
  input wire logic MEAS_DONE,
  input wire meas_t MEAS,
  input wire logic CFG_WRITE,
  // open-drain alert pin
  output logic ALERT_O,
  output logic ALERT_OE
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (DATA_W != 16) begin : g_bad_width
      $error("register bank supports 16-bit data only");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic rst_core_n;
  logic req_s;
  logic req_seen_r, req_seen_nxt;
  logic ack_tgl_r, ack_tgl_nxt;
  logic [15:0] rd_hold_r, rd_hold_nxt;
  logic req_tgl;
  reg_req_t req_hold;
  logic req_fire;
  logic mask_read;
  logic mask_write;
  logic limit_write;
  logic [15:0] mask_ctl_r, mask_ctl_nxt;
  logic [15:0] limit_r, limit_nxt;
  logic limit_flag_r, limit_flag_nxt;
  logic conv_flag_r, conv_flag_nxt;
  logic ovf_r, ovf_nxt;
  logic fault;
  logic alert_act;
  logic alert_o_nxt, alert_oe_nxt;

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  // the highest enabled function bit wins; used by compare and pin logic
  function automatic limit_fn_t pick_fn(input logic [15:0] ctl);
    limit_fn_t fn;
    fn = FN_NONE;
    if (ctl[`BIT_CUR_OVER]) begin
      fn = FN_CUR_OVER;
    end else if (ctl[`BIT_CUR_UNDER]) begin
      fn = FN_CUR_UNDER;
    end else if (ctl[`BIT_BUS_OVER]) begin
      fn = FN_BUS_OVER;
    end else if (ctl[`BIT_BUS_UNDER]) begin
      fn = FN_BUS_UNDER;
    end else if (ctl[`BIT_PWR_OVER]) begin
      fn = FN_PWR_OVER;
    end
    return fn;
  endfunction

  // current is two's complement, bus voltage and power are unsigned;
  // the limit is read in whichever format the chosen result uses
  function automatic logic limit_hit(input limit_fn_t fn,
                                     input meas_t m,
                                     input logic [15:0] lim);
    logic hit;
    hit = 1'b0;
    case (fn)
      FN_CUR_OVER: begin
        hit = $signed(m.current) > $signed(lim);
      end
      FN_CUR_UNDER: begin
        hit = $signed(m.current) < $signed(lim);
      end
      FN_BUS_OVER: begin
        hit = m.bus_volt > lim;
      end
      FN_BUS_UNDER: begin
        hit = m.bus_volt < lim;
      end
      FN_PWR_OVER: begin
        hit = m.power > lim;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------------
  // reset release and link crossing
  // ----------------------------------------------------------------------
  // reset asserts at once but releases on CLK through two flops
  sync_bit u_rst_core (
    .clk(CLK),
    .rst_n(RST_N),
    .d(1'b1),
    .q(rst_core_n)
  );

  // request toggle from the link side
  sync_bit u_req (
    .clk(CLK),
    .rst_n(rst_core_n),
    .d(req_tgl),
    .q(req_s)
  );

  // link-domain holder of the request and the answer
  link_port u_link (
    .link_clk(LINK_CLK),
    .rst_n(RST_N),
    .start(REG_START),
    .req(REG_REQ),
    .ack_tgl(ack_tgl_r),
    .core_rdata(rd_hold_r),
    .req_hold(req_hold),
    .req_tgl(req_tgl),
    .rdata(REG_RDATA),
    .done(REG_DONE),
    .busy(REG_BUSY)
  );

  // one access per toggle; req_hold is settled by the time req_s moves
  assign req_fire = req_s ^ req_seen_r;
  assign mask_read = req_fire && !req_hold.write &&
                     (req_hold.addr == `ADDR_MASK_ENABLE);
  assign mask_write = req_fire && req_hold.write &&
                      (req_hold.addr == `ADDR_MASK_ENABLE);
  assign limit_write = req_fire && req_hold.write &&
                       (req_hold.addr == `ADDR_ALERT_LIMIT);

  // ----------------------------------------------------------------------
  // register read and answer path
  // ----------------------------------------------------------------------
  // read data is loaded in the same cycle as the answer toggle and then held, so the link side
  // samples a stable word; writes answer with zero
  always_comb begin
    req_seen_nxt = req_s;
    ack_tgl_nxt = ack_tgl_r;
    rd_hold_nxt = rd_hold_r;
    if (req_fire) begin
      ack_tgl_nxt = ~ack_tgl_r;
      rd_hold_nxt = `UNMAPPED_READ;
      if (!req_hold.write) begin
        case (req_hold.addr)
          `ADDR_MASK_ENABLE: begin
            rd_hold_nxt = mask_ctl_r;
            rd_hold_nxt[`BIT_LIMIT_FLAG] = limit_flag_r;
            rd_hold_nxt[`BIT_CONV_DONE] = conv_flag_r;
            rd_hold_nxt[`BIT_MATH_OVF] = ovf_r;
          end
          `ADDR_ALERT_LIMIT: begin
            rd_hold_nxt = limit_r;
          end
          `ADDR_MAKER_ID: begin
            rd_hold_nxt = MAKER_CODE;
          end
          `ADDR_DIE_IDENTIFIER: begin
            rd_hold_nxt = {PART_CODE, REV_CODE};
          end
          default: begin
            rd_hold_nxt = `UNMAPPED_READ;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_core_n) begin
    if (!rst_core_n) begin
      req_seen_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      rd_hold_r <= `RDATA_RESET;
    end else begin
      req_seen_r <= req_seen_nxt;
      ack_tgl_r <= ack_tgl_nxt;
      rd_hold_r <= rd_hold_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // writable control and limit
  // ----------------------------------------------------------------------
  // only enables, polarity and latch take writes; flags and the unused
  // bits stay zero here, identification registers ignore writes
  always_comb begin
    mask_ctl_nxt = mask_ctl_r;
    limit_nxt = limit_r;
    if (mask_write) begin
      mask_ctl_nxt = req_hold.wdata & `MASK_WR_BITS;
    end
    if (limit_write) begin
      limit_nxt = req_hold.wdata;
    end
  end

  always_ff @(posedge CLK or negedge rst_core_n) begin
    if (!rst_core_n) begin
      mask_ctl_r <= `MASK_RESET;
      limit_r <= `LIMIT_RESET;
    end else begin
      mask_ctl_r <= mask_ctl_nxt;
      limit_r <= limit_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // flags updated at each finished result
  // ----------------------------------------------------------------------
  // the compare only looks at MEAS on MEAS_DONE, so alert latency is set
  // by the averaging upstream, not by this block
  assign fault = limit_hit(pick_fn(mask_ctl_r), MEAS, limit_r);

  // a new event beats a clear landing in the same cycle
  always_comb begin
    limit_flag_nxt = limit_flag_r;
    conv_flag_nxt = conv_flag_r;
    ovf_nxt = ovf_r;
    if (MEAS_DONE && fault) begin
      limit_flag_nxt = 1'b1;
    end else if (mask_read && mask_ctl_r[`BIT_LATCH]) begin
      limit_flag_nxt = 1'b0;
    end else if (MEAS_DONE && !mask_ctl_r[`BIT_LATCH]) begin
      limit_flag_nxt = 1'b0;
    end
    if (MEAS_DONE) begin
      conv_flag_nxt = 1'b1;
    end else if (CFG_WRITE || mask_read) begin
      conv_flag_nxt = 1'b0;
    end
    if (MEAS_DONE) begin
      ovf_nxt = MEAS.ovf;
    end
  end

  always_ff @(posedge CLK or negedge rst_core_n) begin
    if (!rst_core_n) begin
      limit_flag_r <= 1'b0;
      conv_flag_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      limit_flag_r <= limit_flag_nxt;
      conv_flag_r <= conv_flag_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // alert pin
  // ----------------------------------------------------------------------
  // pin follows the flags one clock later; it drives only its active
  // level and leaves the idle level to the external pull-up
  assign alert_act = (limit_flag_r && (pick_fn(mask_ctl_r) != FN_NONE)) ||
                     (mask_ctl_r[`BIT_CONV_ALARM] && conv_flag_r);

  always_comb begin
    alert_oe_nxt = alert_act;
    alert_o_nxt = mask_ctl_r[`BIT_POLARITY];
  end

  always_ff @(posedge CLK or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ALERT_OE <= 1'b0;
      ALERT_O <= 1'b0;
    end else begin
      ALERT_OE <= alert_oe_nxt;
      ALERT_O <= alert_o_nxt;
    end
  end

endmodule

// File: verilog/monitor_alert_consts.svh
// constants for the alert, limit and identification register bank
// assumes: included by bare name from the design files, once per unit
`ifndef MONITOR_ALERT_CONSTS_SVH
`define MONITOR_ALERT_CONSTS_SVH

// ----------------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------------
`define ADDR_MASK_ENABLE 8'h06
`define ADDR_ALERT_LIMIT 8'h07
`define ADDR_MAKER_ID 8'hfe
`define ADDR_DIE_IDENTIFIER 8'hff

// ----------------------------------------------------------------------
// mask/enable field positions
// ----------------------------------------------------------------------
`define BIT_CUR_OVER 15
`define BIT_CUR_UNDER 14
`define BIT_BUS_OVER 13
`define BIT_BUS_UNDER 12
`define BIT_PWR_OVER 11
`define BIT_CONV_ALARM 10
`define BIT_LIMIT_FLAG 4
`define BIT_CONV_DONE 3
`define BIT_MATH_OVF 2
`define BIT_POLARITY 1
`define BIT_LATCH 0

// ----------------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------------
`define MASK_WR_BITS 16'hfc03
`define MASK_RESET 16'h0000
`define LIMIT_RESET 16'h0000
`define RDATA_RESET 16'h0000
`define UNMAPPED_READ 16'h0000

`endif

// File: verilog/monitor_alert_pkg.sv
// types shared by the alert register bank and its link-side port
// assumes: compiled before every module that imports it
package monitor_alert_pkg;

  // one averaged conversion result from the measurement engine
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] bus_volt;
    logic [15:0] power;
    logic ovf;
  } meas_t;

  // one register access from the serial protocol engine
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic write;
  } reg_req_t;

  // the one limit function that drives the comparison
  typedef enum logic [2:0] {
    FN_NONE,
    FN_CUR_OVER,
    FN_CUR_UNDER,
    FN_BUS_OVER,
    FN_BUS_UNDER,
    FN_PWR_OVER
  } limit_fn_t;

endpackage

// File: verilog/sync_bit.sv
// two flip-flop synchroniser for one level
// assumes: d changes slowly relative to clk; only q is read downstream
`timescale 1ns/1ps
module sync_bit (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // level in and synchronised level out
  input wire logic d,
  output logic q
);

  logic meta_r;

  // ----------------------------------------------------------------------
  // capture chain; meta_r feeds q and nothing else
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// File: verilog/link_port.sv
// link-domain end of the register access path
// assumes: runs on the protocol engine clock; the core answers by toggle
`timescale 1ns/1ps
`include "monitor_alert_consts.svh"
module link_port
  import monitor_alert_pkg::*;
(
  // link clock and raw reset
  input wire logic link_clk,
  input wire logic rst_n,
  // request from the protocol engine
  input wire logic start,
  input wire reg_req_t req,
  // handshake with the core domain
  input wire logic ack_tgl,
  input wire logic [15:0] core_rdata,
  output reg_req_t req_hold,
  output logic req_tgl,
  // answer to the protocol engine
  output logic [15:0] rdata,
  output logic done,
  output logic busy
);

  logic lrst_n;
  logic ack_s;
  logic ack_seen_r, ack_seen_nxt;
  logic busy_nxt, done_nxt, tgl_nxt;
  logic [15:0] rdata_nxt;
  reg_req_t hold_nxt;

  // link reset releases through two flops of its own clock
  sync_bit u_rst (
    .clk(link_clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(lrst_n)
  );

  // answer toggle from the core domain
  sync_bit u_ack (
    .clk(link_clk),
    .rst_n(lrst_n),
    .d(ack_tgl),
    .q(ack_s)
  );

  // ----------------------------------------------------------------------
  // request and answer sequencing
  // ----------------------------------------------------------------------
  // one access in flight; req_hold stays still until the answer returns,
  // so the core can sample it as a settled word
  always_comb begin
    hold_nxt = req_hold;
    tgl_nxt = req_tgl;
    busy_nxt = busy;
    ack_seen_nxt = ack_seen_r;
    rdata_nxt = rdata;
    done_nxt = 1'b0;
    if (!busy && start) begin
      hold_nxt = req;
      tgl_nxt = ~req_tgl;
      busy_nxt = 1'b1;
    end else if (busy && (ack_s != ack_seen_r)) begin
      ack_seen_nxt = ack_s;
      busy_nxt = 1'b0;
      rdata_nxt = core_rdata; // loaded once the synchronised answer toggle is seen
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_hold <= '0;
      req_tgl <= 1'b0;
      busy <= 1'b0;
      ack_seen_r <= 1'b0;
      rdata <= `RDATA_RESET;
      done <= 1'b0;
    end else begin
      req_hold <= hold_nxt;
      req_tgl <= tgl_nxt;
      busy <= busy_nxt;
      ack_seen_r <= ack_seen_nxt;
      rdata <= rdata_nxt;
      done <= done_nxt;
    end
  end

endmodule

// File: sim/monitor_alert_regs_chk.sv
// port assertions for the alert, limit and identification bank
// assumes: bound to monitor_alert_regs; sees its ports only
`timescale 1ns/1ps
module monitor_alert_regs_chk (
  // clocks and reset
  input wire logic CLK,
  input wire logic LINK_CLK,
  input wire logic RST_N,
  // link side
  input wire logic REG_START,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_DONE,
  input wire logic REG_BUSY,
  // measurement and pin
  input wire logic MEAS_DONE,
  input wire logic ALERT_O,
  input wire logic ALERT_OE
);
  // ----------------------------------------------------------------
  // register link
  // ----------------------------------------------------------------
  property p_take;
    @(posedge LINK_CLK) disable iff (!RST_N)
    REG_START && !REG_BUSY |=> REG_BUSY;
  endproperty
  a_take: assert property (p_take)
    else $error("request not taken");
  property p_answer;
    @(posedge LINK_CLK) disable iff (!RST_N)
    $rose(REG_BUSY) |-> ##[2:20] REG_DONE;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access never answered");
  property p_done_pulse;
    @(posedge LINK_CLK) disable iff (!RST_N)
    REG_DONE |=> !REG_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_done_busy;
    @(posedge LINK_CLK) disable iff (!RST_N)
    REG_DONE |-> !REG_BUSY && $past(REG_BUSY);
  endproperty
  a_done_busy: assert property (p_done_busy)
    else $error("done without a taken request");
  property p_busy_end;
    @(posedge LINK_CLK) disable iff (!RST_N)
    $fell(REG_BUSY) |-> REG_DONE;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy dropped without done");
  property p_rdata;
    @(posedge LINK_CLK) disable iff (!RST_N)
    $changed(REG_RDATA) |-> REG_DONE;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data moved between answers");
  // ----------------------------------------------------------------
  // alert pin
  // ----------------------------------------------------------------
  property p_rise;
    @(posedge CLK) disable iff (!RST_N)
    $rose(ALERT_OE) |-> $past(MEAS_DONE, 2);
  endproperty
  a_rise: assert property (p_rise)
    else $error("pin raised away from a result");
  property p_steady;
    @(posedge CLK) disable iff (!RST_N)
    ALERT_OE && $past(ALERT_OE) |-> $stable(ALERT_O);
  endproperty
  a_steady: assert property (p_steady)
    else $error("active level moved while driven");
endmodule
bind monitor_alert_regs monitor_alert_regs_chk u_chk (
  .CLK(CLK), .LINK_CLK(LINK_CLK), .RST_N(RST_N),
  .REG_START(REG_START), .REG_RDATA(REG_RDATA), .REG_DONE(REG_DONE),
  .REG_BUSY(REG_BUSY), .MEAS_DONE(MEAS_DONE), .ALERT_O(ALERT_O),
  .ALERT_OE(ALERT_OE)
);

// File: sim/alert_host_model.sv
// host model: register accesses on the link, pull-up on the pin
// assumes: the bench calls access; one access at a time
`timescale 1ns/1ps
module alert_host_model
  import monitor_alert_pkg::*;
(
  // link clock and answer
  input wire logic link_clk,
  input wire logic busy,
  input wire logic done,
  // open-drain pin halves
  input wire logic pin_o,
  input wire logic pin_oe,
  // request out and resolved pin
  output logic start,
  output reg_req_t req,
  output logic pin
);
  // pull-up wins while the block floats the pin
  assign pin = pin_oe ? pin_o : 1'b1;
  initial begin
    start = 1'b0;
    req = '0;
  end
  // gap idles first so a slow host is covered too; the caller
  // gives the limit in the selected result's format
  task automatic access(input logic [7:0] a, input logic [15:0] d,
                        input logic w, input int gap, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap) @(posedge link_clk);
    @(posedge link_clk);
    #1;
    start = 1'b1;
    req = '{addr: a, wdata: d, write: w};
    @(posedge link_clk);
    #1;
    start = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      if (done === 1'b1 && busy === 1'b0) ok = 1'b1;
      else begin
        @(posedge link_clk);
        #1;
      end
    end
    req = ~req; // no stale request left on the lines
  endtask
endmodule

// File: sim/monitor_alert_limit_and_id_regs_bench.sv
// self-checking bench for the alert, limit and id register bank
// assumes: host model owns the link; bench drives results
`timescale 1ns/1ps
module monitor_alert_limit_and_id_regs_bench
  import monitor_alert_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h7e51; // arbitrary value
  localparam logic [11:0] PART = 12'h6d2; // arbitrary value
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic meas_done = 1'b0;
  meas_t meas = '0;
  logic cfg_write = 1'b0;
  logic start, done, busy, alert_o, alert_oe, pin;
  reg_req_t req;
  logic [15:0] rdata;
  logic [15:0] exp_q[$];
  int fail_count = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  always #15 link_clk = ~link_clk;
  monitor_alert_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART),
    .REV_CODE(REV)) u_dut (
    .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .REG_START(start),
    .REG_REQ(req), .REG_RDATA(rdata), .REG_DONE(done),
    .REG_BUSY(busy), .MEAS_DONE(meas_done), .MEAS(meas),
    .CFG_WRITE(cfg_write), .ALERT_O(alert_o), .ALERT_OE(alert_oe)
  );
  alert_host_model u_host (
    .link_clk(link_clk), .busy(busy), .done(done), .pin_o(alert_o),
    .pin_oe(alert_oe), .start(start), .req(req), .pin(pin)
  );
  // ----------------------------------------------------------------
  // comparison, verdict and stimulus tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // writes answer zero; the note goes in before the request
  task automatic rw(input logic [7:0] a, input logic [15:0] d,
                    input logic w, input logic [15:0] e);
    bit ok;
    exp_q.push_back(w ? 16'h0000 : e);
    u_host.access(a, d, w, $urandom_range(2), ok);
    if (!ok) begin
      fail_count++;
      final_report();
    end
  endtask
  // one finished result, then wait until the pin has settled
  task automatic result(input logic [15:0] v, input logic [15:0] pw,
                        input logic ovf);
    @(posedge clk);
    #1;
    meas_done = 1'b1;
    meas = '{current: v, bus_volt: v, power: pw, ovf: ovf};
    @(posedge clk);
    #1;
    meas_done = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 20 && alert_oe !== 1'b0; n++) @(posedge clk);
    #1;
    if (n == 20) begin
      fail_count++;
      final_report();
    end
  endtask
  // answers are matched against the oldest note
  always @(posedge link_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) check("notes", 16'(exp_q.size()), 16'h0001);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [15:0] m, lim;
    void'($urandom(2));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge link_clk);
    check("pin idle", {15'h0, pin}, 16'h0001);
    rw(8'h06, 16'h0000, 1'b0, 16'h0000);
    rw(8'h07, 16'h0000, 1'b0, 16'h0000);
    rw(8'hfe, 16'hffff, 1'b1, 16'h0000);
    rw(8'hff, 16'h0000, 1'b1, 16'h0000);
    rw(8'hfe, 16'h0000, 1'b0, MAKER);
    rw(8'hff, 16'h0000, 1'b0, {PART, REV});
    rw(8'h42, 16'h1234, 1'b1, 16'h0000);
    rw(8'h42, 16'h0000, 1'b0, 16'h0000);
    rw(8'h06, 16'hffff, 1'b1, 16'h0000);
    rw(8'h06, 16'h0000, 1'b0, 16'hfc03);
    lim = 16'($urandom);
    rw(8'h07, lim, 1'b1, 16'h0000);
    rw(8'h07, 16'h0000, 1'b0, lim);
    rw(8'h07, 16'h1130, 1'b1, 16'h0000);
    // each limit function: a fault, then a value equal to the limit
    for (i = 0; i < 5; i++) begin
      m = 16'h8000 >> i;
      rw(8'h06, m, 1'b1, 16'h0000);
      lim = (i % 2) ? 16'h112f : 16'h1131;
      result(lim, lim, 1'b0);
      check("pin fault", {15'h0, pin}, 16'h0000);
      rw(8'h06, 16'h0000, 1'b0, m | 16'h0018);
      result(16'h1130, 16'h1130, 1'b0);
      check("pin clear", {15'h0, pin}, 16'h0001);
      rw(8'h06, 16'h0000, 1'b0, m | 16'h0008);
    end
    rw(8'h06, 16'h8800, 1'b1, 16'h0000);
    result(16'h1130, 16'h2000, 1'b0);
    check("pin priority", {15'h0, pin}, 16'h0001);
    rw(8'h06, 16'h0000, 1'b0, 16'h8808);
    // latch mode with the inverted pin
    rw(8'h06, 16'h2003, 1'b1, 16'h0000);
    result(16'h1131, 16'h1131, 1'b0);
    check("pin high", {14'h0, alert_oe, pin}, 16'h0003);
    result(16'h1130, 16'h1130, 1'b0);
    check("pin held", {14'h0, alert_oe, pin}, 16'h0003);
    rw(8'h06, 16'h0000, 1'b0, 16'h201b);
    wait_idle();
    check("pin freed", {15'h0, alert_oe}, 16'h0000);
    rw(8'h06, 16'h0000, 1'b0, 16'h2003);
    // overflow follows each result
    rw(8'h06, 16'h0000, 1'b1, 16'h0000);
    result(16'h0000, 16'h0000, 1'b1);
    rw(8'h06, 16'h0000, 1'b0, 16'h000c);
    result(16'h0000, 16'h0000, 1'b0);
    rw(8'h06, 16'h0000, 1'b0, 16'h0008);
    // conversion alarm, cleared by a read and by a config write
    rw(8'h06, 16'h0400, 1'b1, 16'h0000);
    result(16'h0000, 16'h0000, 1'b0);
    check("pin ready", {15'h0, pin}, 16'h0000);
    rw(8'h06, 16'h0000, 1'b0, 16'h0408);
    wait_idle();
    check("pin ready off", {15'h0, pin}, 16'h0001);
    result(16'h0000, 16'h0000, 1'b0);
    @(posedge clk);
    #1;
    cfg_write = 1'b1;
    @(posedge clk);
    #1;
    cfg_write = 1'b0;
    rw(8'h06, 16'h0000, 1'b0, 16'h0400);
    repeat (4) @(posedge link_clk);
    check("notes left", 16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule
